// file: design/port_power_guard.sv
// Four-port power control and protection logic: inrush sequencing,
// overload and clamp timers, clamp setting selection, switch damage.
// Assumes analog comparators give synchronous per-port level inputs.
//
// Function
// R1: Turn-on raises gate, holds inrush current level.
// R2: Inrush expiry with excess current: off, fault.
// R3: Overload only: no restriction, overload timer up.
// R4: Below overload: count down at one sixteenth.
// R5: Overload timer at 60ms: off, fault.
// R6: Clamp always restricts current below clamp level.
// R7: Clamp timer runs when multiplier non-zero.
// R8: Clamp timer at 1.7ms times multiplier: off.
// R9: Multiplier zero: overload timer counts clamp events.
// R10: Inrush forces 425mA clamp, then programmed.
// R11: Port off returns clamp setting to 425mA.
// R12: Host picks 425mA or 850mA by class.
// R13: Host uses clamp codes 00, 40, 80.
// R14: Programmable two-stage foldback per port.
// R15: Three conditions count as switch damage.
// R16: Damage over 180us: disable port, weak pulldown.
// R17: Host recovers by port or chip reset.
// R18: Damage on one port spares the others.
// R19: Open switch gives inrush fault, not damage.
// R20: Two sense scales, 0.5 ohm default.
// R21: Semi-auto high power needs good detection.
// R22: Ports keep fully independent timers and flags.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module port_power_guard
    import port_guard_pkg::*;
#(
    parameter int unsigned PORTS        = 4,            // Number of ports.
    parameter int unsigned INRUSH_CNT   = INRUSH_CYC,   // Inrush length in cycles.
    parameter int unsigned OVERLOAD_CNT = OVERLOAD_CYC, // Overload trip in cycles.
    parameter int unsigned CLAMP_CNT    = CLAMP_CYC     // Clamp unit in cycles.
)
(
    input  wire logic             clk,           // System clock, 100 MHz.
    input  wire logic             rst_n,         // Asynchronous reset, active low.
    input  wire logic [3:0]       addr,          // Register index.
    input  wire logic [15:0]      wdata,         // Write data.
    input  wire logic             wr,            // Write strobe.
    input  wire logic             rd,            // Read strobe.
    output logic      [15:0]      rdata,         // Read data, cycle after rd.
    input  wire logic [PORTS-1:0] over_inrush,   // Current above inrush level.
    input  wire logic [PORTS-1:0] over_overload, // Current above overload threshold.
    input  wire logic [PORTS-1:0] over_clamp,    // Current above clamp threshold.
    input  wire logic [PORTS-1:0] out_powered,   // Port output appears powered.
    input  wire logic [PORTS-1:0] sense_high,    // Sense pin abnormally high.
    input  wire logic [PORTS-1:0] gate_high,     // Gate pin abnormally high.
    input  wire logic [PORTS-1:0] detect_good,   // Latest detection is good.
    output logic      [PORTS-1:0] gate_on,       // Enable gate drive ramp.
    output logic      [PORTS-1:0] inrush_limit,  // Servo gate at inrush level.
    output logic      [PORTS-1:0] weak_pulldown, // Reduced gate pull-down.
    output logic      [PORTS*8-1:0] clamp_code,  // Active clamp code per port.
    output logic      [PORTS*2-1:0] fold_en      // Foldback stage enables.
);

    // Elaboration check: register layout serves exactly four ports.
    if (PORTS != 4)
        $error("port_power_guard supports four ports only");

    // Elaboration check: inrush and overload compares need a count of at least two, the clamp unit at least one; damage count fits 16 bits.
    if (INRUSH_CNT < 2 || OVERLOAD_CNT < 2 || CLAMP_CNT < 1 || DAMAGE_CYC > 16'hffff)
        $error("port_power_guard timer counts out of range");

    localparam int unsigned OW = 32;                   // Timer width.

    // Register state.
    logic [2:0]       cfg_reg;                          // Sense scale, high power, semi.
    logic [7:0]       clamp_prog_reg [PORTS];           // Programmed clamp codes.
    logic [15:0]      mult_reg;                         // Clamp multipliers.
    logic [7:0]       fold_reg;                         // Foldback settings.
    logic [15:0]      fault_reg;                        // Sticky fault flags.
    port_state_e      state_reg [PORTS];                // Port power state.
    logic [OW-1:0]    inrush_reg [PORTS];               // Inrush timer.
    logic [OW-1:0]    ovl_reg [PORTS];                  // Overload timer.
    logic [3:0]       ovl_div_reg [PORTS];              // Count-down prescaler.
    logic [OW-1:0]    clamp_t_reg [PORTS];              // Hard clamp timer.
    logic [15:0]      dmg_reg [PORTS];                  // Damage persistence counter.
    logic [15:0]      fault_set;                        // Fault events this cycle.

    // Default clamp code for the selected sense scale.
    function automatic logic [7:0] clamp_default(input logic quarter);
        clamp_default = quarter ? CLAMP_425_QUARTER : CLAMP_425_HALF;
    endfunction

    // Control register writes.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_reg  <= 3'h0;                           // 0.5 ohm default. [R20]
            mult_reg <= 16'h0000;
            fold_reg <= 8'h00;
            for (int i = 0; i < PORTS; i++)
                clamp_prog_reg[i] <= 8'h00;
        end
        else if (wr)
        begin
            if (addr == ADDR_CFG)
                cfg_reg <= wdata[2:0];
            else if (addr == ADDR_MULT)
                mult_reg <= wdata;
            else if (addr == ADDR_FOLD)
                fold_reg <= wdata[7:0];                 // Two foldback stages each. [R14]
            // Four consecutive indices hold one clamp code per port.
            else if (addr >= ADDR_CLAMP0 && addr < ADDR_MULT)
                clamp_prog_reg[addr[1:0]] <= wdata[7:0];
        end
    end

    // Per-port sequencing, timers and damage detection.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fault_set <= 16'h0000;
            for (int i = 0; i < PORTS; i++)
            begin
                state_reg[i]   <= ST_OFF;
                inrush_reg[i]  <= '0;
                ovl_reg[i]     <= '0;
                ovl_div_reg[i] <= 4'h0;
                clamp_t_reg[i] <= '0;
                dmg_reg[i]     <= 16'h0000;
            end
        end
        else
        begin
            fault_set <= 16'h0000;
            for (int i = 0; i < PORTS; i++)                 // Independent ports. [R22] [R18]
            begin
                logic [3:0] mult;
                logic       cmd_on;
                logic       cmd_off;
                logic       cmd_rst;
                logic       dmg;
                // Command bits for this port, taken from a write to the command index.
                mult    = mult_reg[i*4 +: 4];
                cmd_on  = wr && addr == ADDR_CMD && wdata[CMD_ON_LSB + i];
                cmd_off = wr && addr == ADDR_CMD && wdata[CMD_OFF_LSB + i];
                cmd_rst = wr && addr == ADDR_CMD && wdata[CMD_RST_LSB + i];
                // Any of three damage signs; an open switch shows none. [R15] [R19]
                dmg = (out_powered[i] && state_reg[i] == ST_OFF) || sense_high[i]
                      || gate_high[i];
                // Count consecutive damage cycles; any break restarts the count.
                if (dmg && state_reg[i] != ST_DEAD)
                    dmg_reg[i] <= dmg_reg[i] + 16'h0001;
                else
                    dmg_reg[i] <= 16'h0000;
                if (cmd_rst)
                begin
                    state_reg[i] <= ST_OFF;                 // Host port reset. [R17]
                    dmg_reg[i]   <= 16'h0000;
                end
                else if (dmg && dmg_reg[i] >= 16'(DAMAGE_CYC - 1))
                begin
                    state_reg[i] <= ST_DEAD;                // Disable port. [R16]
                    fault_set[FLT_DAMAGE + i] <= 1'b1;
                end
                else
                begin
                    case (state_reg[i])
                        ST_OFF:
                        begin
                            // Idle: timers held at zero until a turn-on is taken.
                            ovl_reg[i]     <= '0;
                            clamp_t_reg[i] <= '0;
                            inrush_reg[i]  <= '0;
                            if (cmd_on)
                            begin
                                if (cfg_reg[CFG_SEMI] && cfg_reg[CFG_HIPWR] && !detect_good[i])
                                    fault_set[FLT_INRUSH + i] <= 1'b1;      // [R21]
                                else
                                    state_reg[i] <= ST_INRUSH;              // [R1]
                            end
                        end
                        ST_INRUSH:
                        begin
                            // Inrush window: the servo holds current while time runs.
                            inrush_reg[i] <= inrush_reg[i] + 1'b1;
                            if (cmd_off)
                                state_reg[i] <= ST_OFF;
                            else if (inrush_reg[i] >= OW'(INRUSH_CNT - 1))
                            begin
                                if (over_inrush[i])
                                begin
                                    state_reg[i] <= ST_OFF;                 // [R2] [R19]
                                    fault_set[FLT_INRUSH + i] <= 1'b1;
                                end
                                else
                                    state_reg[i] <= ST_ON;
                            end
                        end
                        ST_ON:
                        begin
                            // Full power: both protection timers are live.
                            // Overload timer, also fed by clamp events when mult is 0.
                            if (over_overload[i] || (mult == 4'h0 && over_clamp[i]))
                            begin
                                ovl_reg[i]     <= ovl_reg[i] + 1'b1;       // [R3] [R9]
                                ovl_div_reg[i] <= 4'h0;
                            end
                            else if (ovl_reg[i] != '0)
                            begin
                                ovl_div_reg[i] <= ovl_div_reg[i] + 4'h1;
                                if (ovl_div_reg[i] == 4'(DOWN_RATIO - 1))
                                    ovl_reg[i] <= ovl_reg[i] - 1'b1;       // [R4]
                            end
                            // Hard clamp timer, active with a non-zero multiplier.
                            if (mult != 4'h0 && over_clamp[i])
                                clamp_t_reg[i] <= clamp_t_reg[i] + 1'b1;   // [R7]
                            else
                                clamp_t_reg[i] <= '0;
                            if (cmd_off)
                                state_reg[i] <= ST_OFF;
                            else if (ovl_reg[i] >= OW'(OVERLOAD_CNT - 1))
                            begin
                                state_reg[i] <= ST_OFF;                     // [R5]
                                fault_set[FLT_OVERLOAD + i] <= 1'b1;
                            end
                            else if (mult != 4'h0 &&
                                     clamp_t_reg[i] >= OW'(CLAMP_CNT * mult - 1))
                            begin
                                state_reg[i] <= ST_OFF;                     // [R8]
                                fault_set[FLT_CLAMP + i] <= 1'b1;
                            end
                        end
                        // A damaged port stays dead until a host port reset.
                        default:
                            state_reg[i] <= ST_DEAD;
                    endcase
                end
            end
        end
    end

    // Sticky faults; a set in the clear cycle wins.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            fault_reg <= 16'h0000;
        else if (wr && addr == ADDR_FAULT)
            fault_reg <= (fault_reg & ~wdata) | fault_set;
        else
            fault_reg <= fault_reg | fault_set;
    end

    // Drive outputs from state, all registered.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gate_on       <= '0;
            inrush_limit  <= '0;
            weak_pulldown <= '0;
            clamp_code    <= '0;
            fold_en       <= '0;
        end
        else
        begin
            for (int i = 0; i < PORTS; i++)
            begin
                // Gate drive stays on through inrush and full power.
                gate_on[i]       <= state_reg[i] == ST_INRUSH || state_reg[i] == ST_ON;
                inrush_limit[i]  <= state_reg[i] == ST_INRUSH;                  // [R1]
                weak_pulldown[i] <= state_reg[i] == ST_DEAD;                    // [R16]
                fold_en[i*2 +: 2] <= fold_reg[i*2 +: 2];                         // [R14]
                // Clamp always applied; 425 mA unless fully on. [R6] [R10] [R11]
                if (state_reg[i] == ST_ON)
                    clamp_code[i*8 +: 8] <= clamp_prog_reg[i];
                else
                    clamp_code[i*8 +: 8] <= clamp_default(cfg_reg[CFG_QUARTER]);
            end
        end
    end

    // Read data, one cycle after the strobe.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 16'h0000;
        else if (!rd)
            rdata <= 16'h0000;
        else if (addr == ADDR_CFG)
            rdata <= {13'h0000, cfg_reg};
        else if (addr == ADDR_STATUS)
            rdata <= {12'h000, gate_on};
        else if (addr == ADDR_FAULT)
            rdata <= fault_reg;
        else if (addr >= ADDR_CLAMP0 && addr < ADDR_MULT)
            rdata <= {8'h00, clamp_prog_reg[addr[1:0]]};
        else if (addr == ADDR_MULT)
            rdata <= mult_reg;
        else if (addr == ADDR_FOLD)
            rdata <= {8'h00, fold_reg};
        else
            rdata <= 16'h0000;
    end

    // Each check watches one port; every port shares the same logic.
    // Excess current at the end of the inrush window raises the inrush fault and turns the port off.
    AST_INRUSH_FAULT: assert property (@(posedge clk) disable iff (!rst_n)  // [R2]
        (state_reg[1] == ST_INRUSH && inrush_reg[1] >= OW'(INRUSH_CNT - 1) && over_inrush[1]
         && !wr) |=> fault_set[FLT_INRUSH + 1] && state_reg[1] == ST_OFF)
        else $error("inrush timeout did not fault");
    // An off port shows the default code of the scale seen one cycle earlier.
    AST_CLAMP_OFF: assert property (@(posedge clk) disable iff (!rst_n)  // [R11]
        (state_reg[0] == ST_OFF)
        |=> clamp_code[7:0] == clamp_default($past(cfg_reg[CFG_QUARTER])))
        else $error("clamp code not restored when off");
    // Overload fault rises only after the overload timer reached its trip count.
    AST_OVL_TRIP: assert property (@(posedge clk) disable iff (!rst_n)  // [R5]
        $rose(fault_reg[FLT_OVERLOAD]) |-> $past(ovl_reg[0]) >= OW'(OVERLOAD_CNT - 1))
        else $error("overload fault without timer expiry");
    // Count-down step only after sixteen idle cycles.
    AST_OVL_DOWN: assert property (@(posedge clk) disable iff (!rst_n)  // [R4]
        (state_reg[0] == ST_ON && ovl_reg[0] != '0 && !over_overload[0] && !over_clamp[0]
         && ovl_div_reg[0] != 4'hf) |=> ovl_reg[0] == $past(ovl_reg[0]))
        else $error("overload timer fell too fast");
    // Damage latches the dead state and weak pull-down.
    AST_DAMAGE: assert property (@(posedge clk) disable iff (!rst_n)  // [R16]
        $rose(fault_reg[FLT_DAMAGE + 3]) |-> state_reg[3] == ST_DEAD ##1 weak_pulldown[3])
        else $error("damage fault without disable");
    // Semi-auto high power refuses a bad detection.
    AST_DETECT: assert property (@(posedge clk) disable iff (!rst_n)  // [R21]
        (state_reg[1] == ST_OFF && wr && addr == ADDR_CMD && wdata[CMD_ON_LSB + 1]
         && !wdata[CMD_RST_LSB + 1] && cfg_reg[CFG_SEMI] && cfg_reg[CFG_HIPWR]
         && !detect_good[1] && dmg_reg[1] == 0)
        |=> state_reg[1] == ST_OFF && fault_set[FLT_INRUSH + 1])
        else $error("power-on accepted without good detection");
    // Gate held at inrush level only in inrush.
    AST_INRUSH_LIM: assert property (@(posedge clk) disable iff (!rst_n)  // [R1]
        inrush_limit[0] |-> $past(state_reg[0]) == ST_INRUSH)
        else $error("inrush servo outside inrush");
    // Clamp timer stays idle with zero multiplier.
    AST_CLAMP_IDLE: assert property (@(posedge clk) disable iff (!rst_n)  // [R7]
        (mult_reg[3:0] == 4'h0) |=> clamp_t_reg[0] == '0)
        else $error("clamp timer ran with zero multiplier");

endmodule
`default_nettype wire

// file: design/port_guard_pkg.sv
// Constants shared by the per-port power guard: timing, clamp codes and
// the register map of the plain register port.
// Assumes a 100 MHz system clock.
package port_guard_pkg;

    // Clock rate and documented times.
    localparam int unsigned CLK_HZ             = 100_000_000;
    localparam int unsigned INRUSH_TIME_MS     = 60;      // Inrush timer length in ms.
    localparam int unsigned OVERLOAD_TIME_MS   = 60;      // Overload timer trip in ms.
    localparam int unsigned CLAMP_UNIT_US      = 1700;    // Clamp timer unit, 1.7 ms in us.
    localparam int unsigned DAMAGE_TIME_US     = 180;     // Switch damage persistence in us.
    // Cycle counts derived from the times (damage adds one cycle to exceed its time).
    localparam int unsigned INRUSH_CYC   = CLK_HZ / 1000 * INRUSH_TIME_MS;
    localparam int unsigned OVERLOAD_CYC = CLK_HZ / 1000 * OVERLOAD_TIME_MS;
    localparam int unsigned CLAMP_CYC    = CLK_HZ / 1_000_000 * CLAMP_UNIT_US;
    localparam int unsigned DAMAGE_CYC   = (CLK_HZ / 1_000_000) * DAMAGE_TIME_US + 1;
    localparam int unsigned DOWN_RATIO   = 16;            // Overload count-down divisor.

    // Clamp setting codes.
    localparam logic [7:0] CLAMP_425_HALF    = 8'h00;     // 425 mA at 0.5 ohm sense.
    localparam logic [7:0] CLAMP_425_QUARTER = 8'h80;     // 425 mA at 0.25 ohm sense.

    // Register indices on the register port.
    localparam logic [3:0] ADDR_CMD      = 4'h0;          // Write: on/off/reset per port.
    localparam logic [3:0] ADDR_CFG      = 4'h1;          // Sense scale, high power, semi-auto.
    localparam logic [3:0] ADDR_STATUS   = 4'h2;          // Read: port on bits.
    localparam logic [3:0] ADDR_FAULT    = 4'h3;          // Read: faults, write one to clear.
    localparam logic [3:0] ADDR_CLAMP0   = 4'h4;          // Clamp code of port 0; +port.
    localparam logic [3:0] ADDR_MULT     = 4'h8;          // Clamp multipliers, 4 bits each.
    localparam logic [3:0] ADDR_FOLD     = 4'h9;          // Foldback enables, 2 bits each.

    // Field positions.
    localparam int unsigned CMD_ON_LSB    = 0;            // Bits 3:0 turn ports on.
    localparam int unsigned CMD_OFF_LSB   = 4;            // Bits 7:4 turn ports off.
    localparam int unsigned CMD_RST_LSB   = 8;            // Bits 11:8 reset ports.
    localparam int unsigned CFG_QUARTER   = 0;            // Sense scale 0.25 ohm when set.
    localparam int unsigned CFG_HIPWR     = 1;            // High power mode.
    localparam int unsigned CFG_SEMI      = 2;            // Semi-automatic mode.
    localparam int unsigned FLT_INRUSH    = 0;            // Fault bits 3:0.
    localparam int unsigned FLT_OVERLOAD  = 4;            // Fault bits 7:4.
    localparam int unsigned FLT_CLAMP     = 8;            // Fault bits 11:8.
    localparam int unsigned FLT_DAMAGE    = 12;           // Fault bits 15:12.

    // Per-port power state.
    typedef enum logic [1:0]
    {
        ST_OFF    = 2'b00,
        ST_INRUSH = 2'b01,
        ST_ON     = 2'b11,
        ST_DEAD   = 2'b10
    } port_state_e;

endpackage

// file: tb/switch_load_model.sv
// Behavioural model of the external switch, sense resistor and load.
// Assumes the bench picks each port's load condition as plain levels.
`timescale 1ns/1ps
`default_nettype none
module switch_load_model
(
    input  wire logic [3:0] gate_on,       // Gate drive enable.
    input  wire logic [3:0] inrush_limit,  // Inrush servo active.
    input  wire logic [3:0] heavy,         // Load stays above inrush level.
    input  wire logic [3:0] ovl,           // Load above overload threshold.
    input  wire logic [3:0] clp,           // Load above clamp threshold.
    input  wire logic [3:0] dmg,           // Switch shorted.
    output logic      [3:0] over_inrush,   // Current above inrush level.
    output logic      [3:0] over_overload, // Current above overload threshold.
    output logic      [3:0] over_clamp,    // Current above clamp threshold.
    output logic      [3:0] out_powered,   // Output looks powered.
    output logic      [3:0] sense_high,    // Sense pin high.
    output logic      [3:0] gate_high      // Gate pin high.
);
    // Current flows only while the gate is driven; the servo holds it at the level.
    assign over_inrush   = gate_on & inrush_limit & heavy;
    // The two levels are set apart, so each timer path can be driven alone.
    assign over_overload = gate_on & ovl;
    assign over_clamp    = gate_on & clp;
    // A shorted switch shows on all three damage indicators.
    assign out_powered   = gate_on | dmg;
    assign sense_high    = dmg;
    assign gate_high     = dmg;
endmodule
`default_nettype wire

// file: tb/test_port_power_guard.sv
// Self-checking bench for the four-port power guard.
// Assumes shortened inrush, overload and clamp counts set below.
`timescale 1ns/1ps
`default_nettype none
module test_port_power_guard import port_guard_pkg::*;;
    localparam int unsigned IC = 50; // Inrush cycles.
    logic clk, rst_n, wr, rd;
    logic [3:0] addr, ovi, ovo, ovc, opw, sh, gh, dg, gon, clamp_threshold, wpd, heavy, ovl, clp, dmg;
    logic [15:0] wdata, rdata;
    logic [31:0] ccode;
    logic [7:0]  fold;
    int          n_errors, tests_run;

    port_power_guard #(.INRUSH_CNT(IC), .OVERLOAD_CNT(200), .CLAMP_CNT(20)) dut_u
    (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
     .rdata(rdata), .over_inrush(ovi), .over_overload(ovo), .over_clamp(ovc),
     .out_powered(opw), .sense_high(sh), .gate_high(gh), .detect_good(dg),
     .gate_on(gon), .inrush_limit(clamp_threshold), .weak_pulldown(wpd), .clamp_code(ccode),
     .fold_en(fold));
    switch_load_model partner_u
    (.gate_on(gon), .inrush_limit(clamp_threshold), .heavy(heavy), .ovl(ovl), .clp(clp), .dmg(dmg),
     .over_inrush(ovi), .over_overload(ovo), .over_clamp(ovc), .out_powered(opw),
     .sense_high(sh), .gate_high(gh));

    // Free-running 100 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Prints the verdict and ends the run.
    task automatic close_out();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Compares a vector result.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h wanted %h", $time, got, exp);
        end
    endtask
    // Compares a single port bit.
    task automatic chk_bit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    // One-cycle register write.
    task automatic wreg(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // One-cycle register read; data is taken in the following cycle.
    task automatic rreg(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk({16'h0000, rdata}, {16'h0000, e});
    endtask
    // Waits, bounded, for a port bit of gate (0), servo (1) or pull-down (2) to reach v.
    task automatic wait_on(input int sel, input int p, input logic v, input int lim);
        logic [3:0] s;
        for (int i = 0; i < lim; i++)
        begin
            @(posedge clk);
            #1;
            s = (sel == 0) ? gon : (sel == 1) ? clamp_threshold : wpd;
            if (s[p] === v)
                return;
        end
        n_errors++;
        $display("unexpected at %0t: wait ran out", $time);
        close_out();
    endtask
    // Main sequence.
    initial
    begin
        {rst_n, wr, rd, addr, wdata, heavy, ovl, clp, dmg} = '0;
        dg = 4'hf;
        n_errors = 0;
        tests_run = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(ccode, 32'h0);
        wreg(ADDR_CFG, 16'h0001);
        repeat (3) @(posedge clk);
        #1;
        chk(ccode, 32'h80808080);
        wreg(ADDR_CFG, 16'h0000);
        wreg(ADDR_FOLD, 16'h00a5);
        repeat (3) @(posedge clk);
        #1;
        chk({24'h0, fold}, 32'ha5);
        rreg(4'hf, 16'h0000);
        // Normal turn-on with a programmed clamp code for the high class.
        wreg(ADDR_CLAMP0, 16'h0040);
        wreg(ADDR_CMD, 16'h0001);
        repeat (2) @(posedge clk);
        #1;
        chk_bit(gon[0], 1'b1);
        chk_bit(clamp_threshold[0], 1'b1);
        chk({24'h0, ccode[7:0]}, 32'h00);
        wait_on(1, 0, 1'b0, IC + 10);
        chk({24'h0, ccode[7:0]}, 32'h40);
        rreg(ADDR_STATUS, 16'h0001);
        // Intermittent overload: 100 up, 160 down at 1/16, then trip near 110 more.
        ovl <= 4'h1;
        repeat (100) @(posedge clk);
        ovl <= 4'h0;
        repeat (160) @(posedge clk);
        ovl <= 4'h1;
        repeat (105) @(posedge clk);
        #1;
        chk_bit(gon[0], 1'b1);
        chk_bit(clamp_threshold[0], 1'b0);
        wait_on(0, 0, 1'b0, 20);
        ovl <= 4'h0;
        rreg(ADDR_FAULT, 16'h0010);
        chk({24'h0, ccode[7:0]}, 32'h00);
        wreg(ADDR_FAULT, 16'hffff);
        rreg(ADDR_FAULT, 16'h0000);
        // Load that never settles below the inrush level.
        heavy <= 4'h2;
        wreg(ADDR_CMD, 16'h0002);
        wait_on(0, 1, 1'b0, IC + 10);
        heavy <= 4'h0;
        rreg(ADDR_FAULT, 16'h0002);
        wreg(ADDR_FAULT, 16'hffff);
        // Clamp timer at two units on port 2.
        wreg(ADDR_MULT, 16'h0200);
        wreg(ADDR_CMD, 16'h0004);
        wait_on(1, 2, 1'b0, IC + 10);
        clp <= 4'h4;
        repeat (35) @(posedge clk);
        #1;
        chk_bit(gon[2], 1'b1);
        wait_on(0, 2, 1'b0, 15);
        clp <= 4'h0;
        rreg(ADDR_FAULT, 16'h0400);
        chk({24'h0, ccode[23:16]}, 32'h00);
        wreg(ADDR_FAULT, 16'hffff);
        // Zero multiplier: clamp events run the overload timer instead.
        wreg(ADDR_CMD, 16'h0002);
        wait_on(1, 1, 1'b0, IC + 10);
        clp <= 4'h2;
        repeat (60) @(posedge clk);
        #1;
        chk_bit(gon[1], 1'b1);
        wait_on(0, 1, 1'b0, 160);
        clp <= 4'h0;
        rreg(ADDR_FAULT, 16'h0020);
        wreg(ADDR_FAULT, 16'hffff);
        // Semi-automatic high power with a bad detection result.
        wreg(ADDR_CFG, 16'h0006);
        dg <= 4'h0;
        wreg(ADDR_CMD, 16'h0002);
        repeat (3) @(posedge clk);
        #1;
        chk_bit(gon[1], 1'b0);
        rreg(ADDR_FAULT, 16'h0002);
        wreg(ADDR_FAULT, 16'hffff);
        wreg(ADDR_CFG, 16'h0000);
        dg <= 4'hf;
        // Shorted switch on port 3 while port 0 runs.
        wreg(ADDR_CMD, 16'h0001);
        wait_on(1, 0, 1'b0, IC + 10);
        dmg <= 4'h8;
        repeat (17990) @(posedge clk);
        #1;
        chk_bit(wpd[3], 1'b0);
        wait_on(2, 3, 1'b1, 40);
        rreg(ADDR_FAULT, 16'h8000);
        chk_bit(gon[0], 1'b1);
        chk({24'h0, ccode[7:0]}, 32'h40);
        wreg(ADDR_CMD, 16'h0010);
        repeat (3) @(posedge clk);
        #1;
        chk_bit(gon[0], 1'b0);
        chk({24'h0, ccode[7:0]}, 32'h00);
        dmg <= 4'h0;
        wreg(ADDR_CMD, 16'h0800);
        repeat (3) @(posedge clk);
        #1;
        chk_bit(wpd[3], 1'b0);
        close_out();
    end
endmodule
`default_nettype wire
